// >>> design/plf_top.sv
// Length field generator and checker with Avalon-MM register slave
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "plf_cfg.svh"
module plf_top
    import plf_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // Avalon-MM register slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Element lengths from the composition engine
    input  wire logic        elen_valid_i,
    input  wire plf_elen_s   elen_i,
    // Insert request and transmit byte stream
    input  wire logic        ins_req_i,
    output logic             ins_done_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    output plf_txb_s         tx_o,
    // Receive byte stream
    input  wire logic        rx_valid_i,
    input  wire plf_rxb_s    rx_i,
    // Interrupt
    output logic             irq_o
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] digit(input logic [16:0] c, input logic [1:0] ct,
                                         input logic [1:0] k);
        logic [16:0] q;
        q = c;
        if (ct == `PLF_CT_DEC)
        begin
            for (int i = 0; i < 3; i++)
                if (2'(i) < k)
                    q = q / 17'd10;
            digit = 8'(q % 17'd10);
        end
        else if (ct == `PLF_CT_BIN)
            digit = 8'(c >> {k, 3'h0});
        else
            digit = {4'h0, 4'(c >> {k, 2'h0})};
    endfunction : digit

    function automatic logic [7:0] encode(input logic [7:0] d, input logic [1:0] ct);
        if (ct == `PLF_CT_BIN)
            encode = d;
        else if (d < 8'h0a)
            encode = 8'h30 + d;
        else
            encode = 8'h37 + d;
    endfunction : encode

    // Line position to significance; odd last byte of a swap stays put
    function automatic logic [1:0] sig_of(input logic [1:0] p, input logic [1:0] w1,
                                          input logic [1:0] ord);
        logic [1:0] q;
        q = p;
        if (ord == `PLF_ORD_SWAP && (p ^ 2'h1) <= w1)
            q = p ^ 2'h1;
        sig_of = (ord == `PLF_ORD_REV) ? q : w1 - q;
    endfunction : sig_of

    // Returns {bad, value}
    function automatic logic [8:0] decode(input logic [7:0] b, input logic [1:0] ct);
        decode = {1'b0, b};
        if (ct == `PLF_CT_DEC)
            decode = (b >= 8'h30 && b <= 8'h39) ? {1'b0, b - 8'h30} : 9'h100;
        else if (ct == `PLF_CT_HEX)
        begin
            if (b >= 8'h30 && b <= 8'h39)
                decode = {1'b0, b - 8'h30};
            else if (b >= 8'h41 && b <= 8'h46)
                decode = {1'b0, b - 8'h37};
            else if (b >= 8'h61 && b <= 8'h66)
                decode = {1'b0, b - 8'h57};
            else
                decode = 9'h100;
        end
    endfunction : decode

    // ------------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------------
    logic [31:0] cfg_ff;
    logic [31:0] def_ff;
    logic [4:0]  stat_ff;
    logic [4:0]  mask_ff;
    logic [4:0]  stat_set;
    logic        ack_ff;
    logic [1:0]  ctype;
    logic [1:0]  w1;
    logic [1:0]  order;
    logic [5:0]  first_idx;
    logic [5:0]  last_idx;
    logic        cfg_bad;

    assign ctype     = cfg_ff[`PLF_CFG_CTYPE];
    assign w1        = cfg_ff[`PLF_CFG_WID];
    assign order     = cfg_ff[`PLF_CFG_ORDER];
    assign first_idx = {1'b0, cfg_ff[`PLF_CFG_START]} + 6'h01;
    assign last_idx  = {1'b0, cfg_ff[`PLF_CFG_END]} + 6'h01;

    assign cfg_bad = (order == `PLF_ORD_REV && w1 == 2'h0)
                   || order == 2'h3 || ctype == 2'h3
                   || def_ff[`PLF_DEF_LCNT] > 2'h1
                   || (def_ff[`PLF_DEF_LCNT] != 2'h0
                       && def_ff[`PLF_DEF_ECNT] == 6'h01)
                   || first_idx > last_idx;

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait state, answer at second edge
    // ------------------------------------------------------------------
    logic        req;
    logic [31:0] be_mask;
    logic [31:0] rd_mux;
    logic [16:0] rx_meas_ff;
    logic [16:0] tx_val_ff;

    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_ff;
    assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    always_comb
    begin
        unique case (avs_address_i)
            `PLF_OFS_CFG:   rd_mux = cfg_ff;
            `PLF_OFS_DEF:   rd_mux = def_ff;
            `PLF_OFS_STAT:  rd_mux = {27'h0, stat_ff};
            `PLF_OFS_MASK:  rd_mux = {27'h0, mask_ff};
            `PLF_OFS_RXCNT: rd_mux = {15'h0, rx_meas_ff};
            `PLF_OFS_TXCNT: rd_mux = {15'h0, tx_val_ff};
            default:        rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= req & ~ack_ff;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            avs_readdata_o <= 32'h0;
        else if (avs_read_i & ~ack_ff)
            avs_readdata_o <= rd_mux;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            cfg_ff  <= `PLF_CFG_RST;
            def_ff  <= `PLF_DEF_RST;
            mask_ff <= `PLF_MASK_RST;
        end
        else if (avs_write_i & ack_ff)
        begin
            if (avs_address_i == `PLF_OFS_CFG)
                cfg_ff <= ((cfg_ff & ~be_mask) | (avs_writedata_i & be_mask))
                          & 32'h001f_1f3f;
            if (avs_address_i == `PLF_OFS_DEF)
                def_ff <= ((def_ff & ~be_mask) | (avs_writedata_i & be_mask))
                          & 32'h0000_033f;
            if (avs_address_i == `PLF_OFS_MASK && avs_byteenable_i[0])
                mask_ff <= avs_writedata_i[4:0];
        end
    end

    // Read clears only the bits it reported, so an event set after the load is not lost
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            stat_ff <= 5'h00;
        else if (avs_read_i & ack_ff && avs_address_i == `PLF_OFS_STAT)
            stat_ff <= (stat_ff & ~avs_readdata_o[4:0]) | stat_set;
        else
            stat_ff <= stat_ff | stat_set;
    end

    assign irq_o = |(stat_ff & mask_ff);

    // ------------------------------------------------------------------
    // Transmit: accumulate range length, emit formatted field
    // ------------------------------------------------------------------
    plf_tx_e     tx_st_ff;
    logic [16:0] acc_ff;
    logic [1:0]  pos_ff;
    logic        elen_hit;
    logic        tx_beat;
    logic        tx_end;
    logic        tx_go;
    logic [1:0]  nxt_pos;

    assign elen_hit = elen_valid_i && elen_i.idx >= first_idx && elen_i.idx <= last_idx;
    assign tx_beat  = tx_valid_o & tx_ready_i;
    assign tx_end   = tx_beat && pos_ff == w1;
    assign tx_go    = tx_st_ff == TX_IDLE && ins_req_i && !cfg_bad;
    assign nxt_pos  = tx_go ? 2'h0 : pos_ff + 2'h1;
    assign tx_valid_o = tx_st_ff == TX_SEND;

    // Inclusive range of whole elements
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            acc_ff <= 17'h0;
        else if (tx_end)
            acc_ff <= elen_hit ? {5'h0, elen_i.len} : 17'h0;
        else if (elen_hit)
            acc_ff <= acc_ff + {5'h0, elen_i.len};
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_st_ff  <= TX_IDLE;
            pos_ff    <= 2'h0;
            tx_val_ff <= 17'h0;
        end
        else
        begin
            unique case (tx_st_ff)
                TX_IDLE:
                    if (tx_go)
                    begin
                        tx_st_ff  <= TX_SEND;
                        pos_ff    <= 2'h0;
                        tx_val_ff <= acc_ff;
                    end
                TX_SEND:
                    if (tx_end)
                        tx_st_ff <= TX_IDLE;
                    else if (tx_beat)
                        pos_ff <= pos_ff + 2'h1;
            endcase
        end
    end

    // Byte held in a register; the next one is formed ahead of each beat
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            tx_o <= '0;
        else if (tx_go || (tx_beat && !tx_end))
        begin
            tx_o.data <= encode(digit(tx_go ? acc_ff : tx_val_ff, ctype,
                                      sig_of(nxt_pos, w1, order)), ctype);
            tx_o.last <= nxt_pos == w1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            ins_done_o <= 1'b0;
        else
            ins_done_o <= tx_end || (tx_st_ff == TX_IDLE && ins_req_i && cfg_bad);
    end

    // ------------------------------------------------------------------
    // Receive: measure range, capture field, compare at packet end
    // ------------------------------------------------------------------
    logic [16:0] rx_cnt_ff;
    logic [7:0]  fld_ff [4];
    logic [1:0]  rpos_ff;
    logic        in_len_ff;
    logic        eval_ff;
    logic        rx_hit;
    logic        len_beat;
    logic [5:0]  len_idx;
    logic        mism;
    logic        chbad;
    logic [8:0]  dec_v;

    assign len_idx  = {1'b0, def_ff[`PLF_DEF_LIDX]} + 6'h01;
    assign rx_hit   = rx_valid_i && rx_i.idx >= first_idx && rx_i.idx <= last_idx;
    assign len_beat = rx_valid_i && rx_i.idx == len_idx && rpos_ff <= w1;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            rx_cnt_ff <= 17'h0;
        else if (eval_ff)
            rx_cnt_ff <= rx_hit ? 17'h1 : 17'h0;
        else if (rx_hit)
            rx_cnt_ff <= rx_cnt_ff + 17'h1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            rpos_ff <= 2'h0;
            eval_ff <= 1'b0;
            fld_ff  <= '{default: 8'h30};
        end
        else
        begin
            eval_ff <= rx_valid_i & rx_i.last & ~eval_ff;
            if (len_beat)
            begin
                fld_ff[sig_of(rpos_ff, w1, order)] <= rx_i.data;
                if (rpos_ff != w1)
                    rpos_ff <= rpos_ff + 2'h1;
            end
            if (eval_ff)
                rpos_ff <= 2'h0;
        end
    end

    // Low digits only are compared, so a longer count truncates alike
    always_comb
    begin
        mism  = 1'b0;
        chbad = 1'b0;
        dec_v = 9'h0;
        for (int k = 0; k < 4; k++)
        begin
            dec_v = decode(fld_ff[k], ctype);
            if (2'(k) <= w1)
            begin
                chbad = chbad | dec_v[8];
                if (dec_v[7:0] != digit(rx_cnt_ff, ctype, 2'(k)))
                    mism = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            rx_meas_ff <= 17'h0;
        else if (eval_ff)
            rx_meas_ff <= rx_cnt_ff;
    end

    always_comb
    begin
        stat_set = 5'h00;
        stat_set[`PLF_ST_TXDONE]  = tx_end;
        stat_set[`PLF_ST_CFGERR]  = (tx_st_ff == TX_IDLE && ins_req_i && cfg_bad)
                                  || (eval_ff && cfg_bad);
        stat_set[`PLF_ST_RXOK]    = eval_ff && !cfg_bad && !mism && !chbad;
        stat_set[`PLF_ST_RXBAD]   = eval_ff && !cfg_bad && (mism || chbad);
        stat_set[`PLF_ST_CHARERR] = eval_ff && !cfg_bad && chbad;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_go;
        tx_st_ff == TX_IDLE && ins_req_i && !cfg_bad;
    endsequence
    sequence s_refuse;
        tx_st_ff == TX_IDLE && ins_req_i && cfg_bad;
    endsequence

    tx_starts_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_go |=> tx_valid_o && tx_val_ff == $past(acc_ff))
        else $error("Insert request did not start the field");
    fwd_msb_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_go and (order == `PLF_ORD_FWD && ctype == `PLF_CT_BIN && w1 == 2'h1)
        |=> tx_o.data == tx_val_ff[15:8])
        else $error("Forward order did not lead with the high byte");
    trunc_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_go and (ctype == `PLF_CT_BIN && w1 == 2'h0)
        |=> tx_o.data == tx_val_ff[7:0] && tx_o.last)
        else $error("Single byte field not truncated to low byte");
    hex_chars_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        tx_valid_o && ctype == `PLF_CT_HEX
        |-> (tx_o.data inside {[8'h30:8'h39], [8'h41:8'h46]}))
        else $error("Hex field byte is not a hex character");
    rev_refused_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_refuse and (order == `PLF_ORD_REV && w1 == 2'h0)
        |=> !tx_valid_o && ins_done_o && stat_ff[`PLF_ST_CFGERR])
        else $error("Reverse order on one byte was not refused");
    field_beats_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(tx_valid_o) && w1 == 2'h3 ##0 tx_ready_i [*4]
        |-> tx_valid_o && $past(tx_valid_o) && $past(tx_valid_o, 2) ##1 !tx_valid_o)
        else $error("Four byte field did not take four beats");
    range_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        rx_valid_i && !rx_hit && !eval_ff |=> rx_cnt_ff == $past(rx_cnt_ff))
        else $error("Out of range byte was counted");
    rx_verdict_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        eval_ff && !cfg_bad && chbad
        |=> stat_ff[`PLF_ST_RXBAD] && stat_ff[`PLF_ST_CHARERR])
        else $error("Bad length character not flagged as mismatch");
endmodule : plf_top
`default_nettype wire

// >>> design/plf_cfg.svh
// Register map, field positions and reset values of the length field unit
`ifndef PLF_CFG_SVH
`define PLF_CFG_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PLF_OFS_CFG     5'h00
`define PLF_OFS_DEF     5'h04
`define PLF_OFS_STAT    5'h08
`define PLF_OFS_MASK    5'h0c
`define PLF_OFS_RXCNT   5'h10
`define PLF_OFS_TXCNT   5'h14
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PLF_CFG_CTYPE   1:0
`define PLF_CFG_WID     3:2
`define PLF_CFG_ORDER   5:4
`define PLF_CFG_START   12:8
`define PLF_CFG_END     20:16
`define PLF_DEF_ECNT    5:0
`define PLF_DEF_LCNT    9:8
`define PLF_DEF_LIDX    14:10
`define PLF_ST_TXDONE   0
`define PLF_ST_RXOK     1
`define PLF_ST_RXBAD    2
`define PLF_ST_CFGERR   3
`define PLF_ST_CHARERR  4
// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define PLF_CT_HEX      2'h0
`define PLF_CT_DEC      2'h1
`define PLF_CT_BIN      2'h2
`define PLF_ORD_FWD     2'h0
`define PLF_ORD_REV     2'h1
`define PLF_ORD_SWAP    2'h2
`define PLF_CFG_RST     32'h0001_0104
`define PLF_DEF_RST     32'h0000_0102
`define PLF_MASK_RST    5'h00
`endif

// >>> design/plf_pkg.sv
// Types shared by the length field unit
package plf_pkg;
    typedef struct packed {
        logic [5:0]  idx;
        logic [11:0] len;
    } plf_elen_s;
    typedef struct packed {
        logic [7:0] data;
        logic [5:0] idx;
        logic       last;
    } plf_rxb_s;
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } plf_txb_s;
    typedef enum logic {TX_IDLE, TX_SEND} plf_tx_e;
endpackage : plf_pkg

// >>> tb/plf_peer.sv
// Far-side serial device model: stalling byte sink and packet source
`timescale 1ns/1ps
`default_nettype none
module plf_peer
    import plf_pkg::*;
(
    // Clock and reset
    input  wire logic     core_clk_i,
    input  wire logic     sys_rst_i,
    // Transmit stream from the unit
    input  wire logic     tx_valid_i,
    input  wire plf_txb_s tx_i,
    output logic          tx_ready_o,
    input  wire logic     stall_i,
    // Receive stream into the unit
    output logic          rx_valid_o,
    output plf_rxb_s      rx_o
);
    logic [8:0] txq[$];

    initial
    begin
        rx_valid_o = 1'b0;
        rx_o = '0;
    end

    // Stall mode takes every other beat only
    always @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            tx_ready_o <= 1'b0;
        else
            tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
        if (tx_valid_i && tx_ready_o)
            txq.push_back({tx_i.data, tx_i.last});
    end

    task automatic send_byte(input logic [5:0] idx, input logic [7:0] b, input logic last);
        rx_valid_o <= 1'b1;
        rx_o <= '{data: b, idx: idx, last: last};
        @(posedge core_clk_i);
        // Idle line shows the inverse so no stale byte can pass
        if (last)
        begin
            rx_valid_o <= 1'b0;
            rx_o <= '{data: ~b, idx: ~idx, last: 1'b0};
        end
    endtask : send_byte
endmodule : plf_peer
`default_nettype wire

// >>> tb/tb_plf_top.sv
// Self-checking bench for the packet length field unit
`timescale 1ns/1ps
`default_nettype none
`include "plf_cfg.svh"
module tb_plf_top;
    import plf_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [4:0]  avs_address_i = 5'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        elen_valid_i = 1'b0;
    plf_elen_s   elen_i = '0;
    logic        ins_req_i = 1'b0;
    logic        ins_done_o;
    logic        tx_valid_o;
    logic        tx_ready_i;
    plf_txb_s    tx_o;
    logic        rx_valid_i;
    plf_rxb_s    rx_i;
    logic        irq_o;
    logic        stall = 1'b0;
    int          n_mismatch = 0;
    int          check_count = 0;

    always #5 core_clk_i = ~core_clk_i;

    plf_top plf_top_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .elen_valid_i(elen_valid_i), .elen_i(elen_i), .ins_req_i(ins_req_i),
        .ins_done_o(ins_done_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
        .tx_o(tx_o), .rx_valid_i(rx_valid_i), .rx_i(rx_i), .irq_o(irq_o));

    plf_peer plf_peer_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .tx_valid_i(tx_valid_o), .tx_i(tx_o), .tx_ready_o(tx_ready_i), .stall_i(stall),
        .rx_valid_o(rx_valid_i), .rx_o(rx_i));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic timeout();
        n_mismatch++;
        $display("[ERR] handshake expected answer seen none");
        finish_test();
    endtask : timeout

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= ~w;
        n = 0;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        if (avs_waitrequest_o !== 1'b0)
            timeout();
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, q, exp);
    endtask : rd_chk

    task automatic ins();
        int n;
        ins_req_i <= 1'b1;
        @(posedge core_clk_i);
        ins_req_i <= 1'b0;
        n = 0;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (ins_done_o !== 1'b1 && n < 100);
        if (ins_done_o !== 1'b1)
            timeout();
    endtask : ins

    task automatic elem(input logic [5:0] idx, input logic [11:0] len);
        elen_valid_i <= 1'b1;
        elen_i <= '{idx: idx, len: len};
        @(posedge core_clk_i);
    endtask : elem

    // Element length if its index lies in the configured range
    function automatic logic [31:0] in_rng(input logic [31:0] cfg, input logic [5:0] idx,
                                           input logic [11:0] len);
        in_rng = (idx > {1'b0, cfg[`PLF_CFG_START]} && idx <= {1'b0, cfg[`PLF_CFG_END]} + 6'h01)
                 ? {20'h0, len} : 32'h0;
    endfunction : in_rng

    task automatic do_tx(input logic [31:0] cfg, input logic [5:0] i3, input logic [11:0] l2,
                         input logic [11:0] l3, input int nb, input logic [31:0] exp,
                         input logic st);
        int n;
        wr(`PLF_OFS_CFG, cfg);
        stall <= st;
        plf_peer_inst.txq.delete();
        elem(6'h02, l2);
        elem(i3, l3);
        elem(6'h04, 12'h005);
        elen_valid_i <= 1'b0;
        ins();
        chk("tx bytes", 32'(plf_peer_inst.txq.size()), 32'(nb));
        for (n = 0; n < nb && n < plf_peer_inst.txq.size(); n++)
            chk("tx byte", {23'h0, plf_peer_inst.txq[n]}, {23'h0, exp[8*(nb-1-n) +: 8], n == nb-1});
        rd_chk("tx stat", `PLF_OFS_STAT, 32'h01);
        rd_chk("tx count", `PLF_OFS_TXCNT, in_rng(cfg, 6'h02, l2) + in_rng(cfg, i3, l3)
               + in_rng(cfg, 6'h04, 12'h005));
    endtask : do_tx

    task automatic do_rx(input logic [31:0] cfg, input logic [7:0] b0, input logic [7:0] b1,
                         input int np, input logic [31:0] st);
        int n;
        wr(`PLF_OFS_CFG, cfg);
        plf_peer_inst.send_byte(6'h01, b0, 1'b0);
        plf_peer_inst.send_byte(6'h01, b1, 1'b0);
        for (n = 0; n < np; n++)
            plf_peer_inst.send_byte(6'h02, 8'h55, 1'b0);
        plf_peer_inst.send_byte(6'h03, 8'h0d, 1'b1);
        repeat (3) @(posedge core_clk_i);
        rd_chk("rx stat", `PLF_OFS_STAT, st);
        rd_chk("rx count", `PLF_OFS_RXCNT, 32'(np));
    endtask : do_rx

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rd_chk("cfg reset", `PLF_OFS_CFG, `PLF_CFG_RST);
        rd_chk("def reset", `PLF_OFS_DEF, `PLF_DEF_RST);
        rd_chk("mask reset", `PLF_OFS_MASK, 32'h0);
        rd_chk("stat reset", `PLF_OFS_STAT, 32'h0);
        wr(5'h1c, 32'hffff_ffff);
        rd_chk("unmapped", 5'h1c, 32'h0);
        wr(`PLF_OFS_DEF, 32'h0000_0105);
        rd_chk("def write", `PLF_OFS_DEF, 32'h0000_0105);
        $display("test regs done");
    endtask : t_regs

    task automatic t_tx();
        do_tx(32'h0002_0104, 6'h03, 12'h100, 12'h023, 2, 32'h3233, 1'b1);
        do_tx(32'h0002_0100, 6'h03, 12'h100, 12'h023, 1, 32'h33, 1'b0);
        do_tx(32'h0002_0106, 6'h03, 12'h100, 12'h023, 2, 32'h0123, 1'b0);
        do_tx(32'h0002_0102, 6'h03, 12'h100, 12'h023, 1, 32'h23, 1'b1);
        do_tx(32'h0002_010c, 6'h03, 12'hab0, 12'h00c, 4, 32'h3041_4243, 1'b1);
        do_tx(32'h0002_0105, 6'h03, 12'h064, 12'h017, 2, 32'h3233, 1'b0);
        do_tx(32'h0002_0119, 6'h03, 12'h064, 12'h017, 3, 32'h33_3231, 1'b1);
        do_tx(32'h0002_012e, 6'h03, 12'h100, 12'h023, 4, 32'h0000_2301, 1'b0);
        do_tx(32'h0002_012a, 6'h03, 12'h100, 12'h023, 3, 32'h01_0023, 1'b1);
        do_tx(32'h001f_1f04, 6'h20, 12'h100, 12'h007, 2, 32'h3037, 1'b0);
        $display("test transmit done");
    endtask : t_tx

    task automatic t_refuse();
        plf_peer_inst.txq.delete();
        wr(`PLF_OFS_CFG, 32'h0002_0110);
        ins();
        rd_chk("rev one byte", `PLF_OFS_STAT, 32'h08);
        wr(`PLF_OFS_CFG, 32'h0002_0104);
        wr(`PLF_OFS_DEF, 32'h0000_0205);
        ins();
        rd_chk("two lengths", `PLF_OFS_STAT, 32'h08);
        wr(`PLF_OFS_DEF, 32'h0000_0101);
        ins();
        rd_chk("length only", `PLF_OFS_STAT, 32'h08);
        wr(`PLF_OFS_DEF, 32'h0000_0105);
        wr(`PLF_OFS_CFG, 32'h0002_0304);
        ins();
        rd_chk("start past end", `PLF_OFS_STAT, 32'h08);
        chk("refused bytes", 32'(plf_peer_inst.txq.size()), 32'h0);
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_rx();
        do_rx(32'h0001_0104, 8'h30, 8'h33, 3, 32'h02);
        do_rx(32'h0001_0104, 8'h30, 8'h34, 3, 32'h04);
        do_rx(32'h0001_0104, 8'h30, 8'h61, 10, 32'h02);
        do_rx(32'h0001_0104, 8'h30, 8'h67, 3, 32'h14);
        do_rx(32'h0001_0105, 8'h31, 8'h30, 10, 32'h02);
        do_rx(32'h0001_0105, 8'h30, 8'h41, 10, 32'h14);
        do_rx(32'h0001_0106, 8'h00, 8'h03, 3, 32'h02);
        do_rx(32'h0001_0114, 8'h33, 8'h30, 3, 32'h02);
        do_rx(32'h0001_0126, 8'h03, 8'h00, 3, 32'h02);
        $display("test receive done");
    endtask : t_rx

    task automatic t_irq();
        wr(`PLF_OFS_MASK, 32'h08);
        wr(`PLF_OFS_CFG, 32'h0002_0110);
        ins();
        wr(`PLF_OFS_MASK, 32'h00);
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        wr(`PLF_OFS_MASK, 32'h08);
        chk("irq raised", {31'h0, irq_o}, 32'h1);
        rd_chk("irq stat", `PLF_OFS_STAT, 32'h08);
        chk("irq cleared", {31'h0, irq_o}, 32'h0);
        $display("test interrupt done");
    endtask : t_irq

    initial
    begin
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        t_regs();
        t_tx();
        t_refuse();
        t_rx();
        t_irq();
        finish_test();
    end
endmodule : tb_plf_top
`default_nettype wire
